// *** design/pmx_pkg.sv ***
// constants shared by the port 3 pin-function multiplexer
package pmx_pkg;

  // pin vector layout: index 0 is port2_bit7, indices 1..8 are port3 bits 0..7
  localparam int PIN_COUNT = 9;
  localparam int PIN_P2B7 = 0;
  localparam int PIN_P3B0 = 1;
  localparam int PIN_P3B1 = 2;
  localparam int PIN_P3B2 = 3;
  localparam int PIN_P3B6 = 7;
  localparam int PIN_P3B7 = 8;

  // register bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // register offsets (byte addresses, one word each)
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] PIN_LEVEL_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] OWNER_OFS = 4'h8;
  localparam logic [ADDR_W-1:0] DRIVE_OFS = 4'hc;

  // control register fields
  localparam int CTRL_W = 8;
  localparam int CTRL_CLKMON_EN = 0;
  localparam int CTRL_CMP_EN_LSB = 1;
  localparam int CMP_CH_COUNT = 4;
  localparam int CTRL_PULSE_A_EN = 5;
  localparam int CTRL_PULSE_B_EN = 6;
  localparam int CTRL_ADC_TRIG_EN = 7;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;

  // status fields beyond the pin vector
  localparam int STAT_ADC_ACTIVE = 9;
  localparam int STAT_ADC_TRIG = 10;

  // reset values
  localparam logic [PIN_COUNT-1:0] PIN_RESET = 9'h000;
  localparam logic [DATA_W-1:0] RDATA_RESET = 16'h0000;

endpackage

// *** design/pmx_sync3.sv ***
// three-stage input synchroniser with agreement filter for the shared pins
`timescale 1ns/100ps
module pmx_sync3
  import pmx_pkg::*;
(
  // clock and control
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // asynchronous pin levels
  input wire logic [pmx_pkg::PIN_COUNT-1:0] async_in,
  // filtered levels in the clock domain
  output logic [pmx_pkg::PIN_COUNT-1:0] level
);

  logic [PIN_COUNT-1:0] stage1;
  logic [PIN_COUNT-1:0] stage2;
  logic [PIN_COUNT-1:0] stage3;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      stage1 <= PIN_RESET;
      stage2 <= PIN_RESET;
      stage3 <= PIN_RESET;
    end
    else if (ce)
    begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // only stages two and three are compared; stage one feeds nothing else
  always_ff @(posedge clk)
  begin
    if (!nrst)
      level <= PIN_RESET;
    else if (ce)
    begin
      for (int i = 0; i < PIN_COUNT; i++)
      begin
        if (stage2[i] == stage3[i])
          level[i] <= stage3[i];
      end
    end
  end

endmodule

// *** design/pmx_pin_cell.sv ***
// output and enable selection for one shared pin
`timescale 1ns/100ps
module pmx_pin_cell
  import pmx_pkg::*;
(
  // clock and control
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // selection
  input wire logic own,
  input wire logic periph,
  input wire logic data,
  input wire logic dir,
  // pin drive
  output logic pin_out,
  output logic pin_oe
);

  function automatic logic pick(input logic sel, input logic a, input logic b);
    pick = sel ? a : b;
  endfunction

  // a peripheral that owns the pin always drives it; else port direction decides
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end
    else if (ce)
    begin
      pin_out <= pick(own, periph, data);
      pin_oe <= pick(own, 1'b1, dir);
    end
  end

endmodule

// *** design/pmx_port3_mux.sv ***
// pin-function multiplexer for port2 bit 7 and the eight port 3 pins
//
// Overview of operation
// - while the converter is operating, the synchronised level of the trigger pin is passed to its trigger input.
// - the clock monitor drives port3 bit 1 only while its output is enabled, else the pin is a port bit.
// - port3 bit 2 is a port bit while compare channel 0 output is disabled and carries its event otherwise.
// - port3 bit 3 is a port bit while compare channel 1 output is disabled and carries its event otherwise.
// - port3 bit 4 is a port bit while compare channel 2 output is disabled and carries its event otherwise.
// - port3 bit 5 is a port bit while compare channel 3 output is disabled and carries its event otherwise.
// - port3 bit 6 carries pulse generator 0 wave a while enabled, else it is a port bit.
// - port3 bit 7 carries pulse generator 0 wave b while enabled, else it is a port bit.
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/100ps
module pmx_port3_mux
  import pmx_pkg::*;
(
  // clock, reset, enable
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  // register bus
  input wire logic [pmx_pkg::ADDR_W-1:0] ADDR,
  input wire logic [pmx_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [pmx_pkg::DATA_W-1:0] RDATA,
  // port data and direction settings
  input wire logic PORT2_BIT7_DATA,
  input wire logic PORT2_BIT7_DIR,
  input wire logic [7:0] PORT3_DATA,
  input wire logic [7:0] PORT3_DIR,
  // port read-back levels
  output logic PORT2_BIT7_LEVEL,
  output logic [7:0] PORT3_LEVEL,
  // peripheral signals
  input wire logic ADC_ACTIVE,
  output logic ADC_EXTERNAL_TRIGGER,
  input wire logic CLOCK_MONITOR,
  input wire logic [3:0] COMPARE_EVENT,
  input wire logic PULSE_GEN0_WAVE_A,
  input wire logic PULSE_GEN0_WAVE_B,
  // shared pin port2_bit7
  input wire logic PORT2_BIT7_IN,
  output logic PORT2_BIT7_OUT,
  output logic PORT2_BIT7_OE,
  // shared pins port3 bits 0..7
  input wire logic [7:0] PORT3_IN,
  output logic [7:0] PORT3_OUT,
  output logic [7:0] PORT3_OE
);

  //////////////////////////////////////////////////////////////////////////////

  logic [CTRL_W-1:0] ctrl;
  logic [PIN_COUNT-1:0] pin_level;
  logic [PIN_COUNT-1:0] own;
  logic [PIN_COUNT-1:0] periph;
  logic [PIN_COUNT-1:0] port_data;
  logic [PIN_COUNT-1:0] port_dir;
  logic [PIN_COUNT-1:0] pin_out;
  logic [PIN_COUNT-1:0] pin_oe;
  logic [PIN_COUNT-1:0] pin_in;
  logic [PIN_COUNT-1:0] owner_seen;
  logic adc_active_seen;
  logic [DATA_W-1:0] next_rdata;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [DATA_W-1:0] widen(input logic [PIN_COUNT-1:0] v);
    widen = {{(DATA_W-PIN_COUNT){1'b0}}, v};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // control register

  always_ff @(posedge CLK)
  begin
    if (!NRST)
      ctrl <= CTRL_RESET;
    else if (CE && WR && hit(ADDR, CTRL_OFS))
      ctrl <= WDATA[CTRL_W-1:0];
  end

  //////////////////////////////////////////////////////////////////////////////
  // read port: data stands in the cycle after the strobe and is held while CE is low

  always_comb
  begin
    next_rdata = RDATA_RESET;
    if (RD)
    begin
      if (hit(ADDR, CTRL_OFS))
        next_rdata = {{(DATA_W-CTRL_W){1'b0}}, ctrl};
      else if (hit(ADDR, PIN_LEVEL_OFS))
      begin
        next_rdata = widen(pin_level);
        next_rdata[STAT_ADC_ACTIVE] = adc_active_seen;
        next_rdata[STAT_ADC_TRIG] = ADC_EXTERNAL_TRIGGER;
      end
      else if (hit(ADDR, OWNER_OFS))
        next_rdata = widen(owner_seen);
      else if (hit(ADDR, DRIVE_OFS))
        next_rdata = widen(pin_oe);
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!NRST)
      RDATA <= RDATA_RESET;
    else if (CE)
      RDATA <= next_rdata;
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin input synchronisation

  assign pin_in = {PORT3_IN, PORT2_BIT7_IN};

  pmx_sync3 u_sync
  (
    .clk(CLK),
    .nrst(NRST),
    .ce(CE),
    .async_in(pin_in),
    .level(pin_level)
  );

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      PORT2_BIT7_LEVEL <= 1'b0;
      PORT3_LEVEL <= 8'h00;
    end
    else if (CE)
    begin
      PORT2_BIT7_LEVEL <= pin_level[PIN_P2B7];
      PORT3_LEVEL <= pin_level[PIN_P3B7:PIN_P3B0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // converter trigger input

  always_ff @(posedge CLK)
  begin
    if (!NRST)
      adc_active_seen <= 1'b0;
    else if (CE)
      adc_active_seen <= ADC_ACTIVE;
  end

  // trigger pass-through
  // the pin is sampled whatever the port does with it, so an own drive makes triggers
  always_ff @(posedge CLK)
  begin
    if (!NRST)
      ADC_EXTERNAL_TRIGGER <= 1'b0;
    else if (CE)
      ADC_EXTERNAL_TRIGGER <= ADC_ACTIVE & pin_level[PIN_P2B7];
  end

  //////////////////////////////////////////////////////////////////////////////
  // ownership of each pin

  always_comb
  begin
    own = PIN_RESET;
    periph = PIN_RESET;
    // trigger pin not seized
    // the converter only listens, so port2_bit7 stays with the port settings
    own[PIN_P2B7] = 1'b0;
    own[PIN_P3B0] = 1'b0;
    own[PIN_P3B1] = ctrl[CTRL_CLKMON_EN];
    periph[PIN_P3B1] = CLOCK_MONITOR;
    for (int i = 0; i < CMP_CH_COUNT; i++)
    begin
      own[PIN_P3B2+i] = ctrl[CTRL_CMP_EN_LSB+i];
      periph[PIN_P3B2+i] = COMPARE_EVENT[i];
    end
    own[PIN_P3B6] = ctrl[CTRL_PULSE_A_EN];
    periph[PIN_P3B6] = PULSE_GEN0_WAVE_A;
    own[PIN_P3B7] = ctrl[CTRL_PULSE_B_EN];
    periph[PIN_P3B7] = PULSE_GEN0_WAVE_B;
  end

  always_ff @(posedge CLK)
  begin
    if (!NRST)
      owner_seen <= PIN_RESET;
    else if (CE)
      owner_seen <= own;
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin drivers

  assign port_data = {PORT3_DATA, PORT2_BIT7_DATA};
  assign port_dir = {PORT3_DIR, PORT2_BIT7_DIR};

  // port fallback drive
  // one registered stage keeps glitches of the select off the pin
  for (genvar g = 0; g < PIN_COUNT; g++)
  begin : g_cell
    pmx_pin_cell u_cell
    (
      .clk(CLK),
      .nrst(NRST),
      .ce(CE),
      .own(own[g]),
      .periph(periph[g]),
      .data(port_data[g]),
      .dir(port_dir[g]),
      .pin_out(pin_out[g]),
      .pin_oe(pin_oe[g])
    );
  end

  assign PORT2_BIT7_OUT = pin_out[PIN_P2B7];
  assign PORT2_BIT7_OE = pin_oe[PIN_P2B7];
  assign PORT3_OUT = pin_out[PIN_P3B7:PIN_P3B0];
  assign PORT3_OE = pin_oe[PIN_P3B7:PIN_P3B0];

endmodule

// *** tb/pmx_port3_mux_monitor.sv ***
// port-level assertions for the pin-function multiplexer
`timescale 1ns/100ps
module pmx_port3_mux_chk
  import pmx_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  // register bus
  input wire logic [pmx_pkg::ADDR_W-1:0] ADDR,
  input wire logic [pmx_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [pmx_pkg::DATA_W-1:0] RDATA,
  // settings and peripherals
  input wire logic [7:0] PORT3_DATA,
  input wire logic [7:0] PORT3_DIR,
  input wire logic ADC_ACTIVE,
  input wire logic ADC_EXTERNAL_TRIGGER,
  input wire logic PORT2_BIT7_LEVEL,
  input wire logic CLOCK_MONITOR,
  input wire logic [3:0] COMPARE_EVENT,
  input wire logic PULSE_GEN0_WAVE_A,
  input wire logic PULSE_GEN0_WAVE_B,
  // pin drive
  input wire logic [7:0] PORT3_OUT,
  input wire logic [7:0] PORT3_OE
);
  logic [7:0] ctl;
  logic [7:0] own;
  logic [7:0] per;
  // control mirror rebuilt from bus writes, so ownership is judged independently
  always_ff @(posedge CLK)
  begin
    if (!NRST)
      ctl <= 8'h00;
    else if (CE && WR && ADDR == CTRL_OFS)
      ctl <= WDATA[7:0];
  end
  assign own = {ctl[6:0], 1'b0};
  assign per = {PULSE_GEN0_WAVE_B, PULSE_GEN0_WAVE_A, COMPARE_EVENT, CLOCK_MONITOR, 1'b0};
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  sequence en_edge;
    CE;
  endsequence
  property pin_sel(int i);
    en_edge |=> PORT3_OE[i] == ($past(own[i]) | $past(PORT3_DIR[i]))
      && PORT3_OUT[i] == ($past(own[i]) ? $past(per[i]) : $past(PORT3_DATA[i]));
  endproperty
  gpio_pin_a: assert property (pin_sel(0)) else $error("bit0 drive wrong");
  clkmon_pin_a: assert property (pin_sel(1)) else $error("bit1 drive wrong");
  cmp0_pin_a: assert property (pin_sel(2)) else $error("bit2 drive wrong");
  cmp1_pin_a: assert property (pin_sel(3)) else $error("bit3 drive wrong");
  cmp2_pin_a: assert property (pin_sel(4)) else $error("bit4 drive wrong");
  cmp3_pin_a: assert property (pin_sel(5)) else $error("bit5 drive wrong");
  wave_a_pin_a: assert property (pin_sel(6)) else $error("bit6 drive wrong");
  wave_b_pin_a: assert property (pin_sel(7)) else $error("bit7 drive wrong");
  trig_idle_a: assert property ((CE && !ADC_ACTIVE) [*3] |=> !ADC_EXTERNAL_TRIGGER) else $error("trigger while idle");
  trig_pass_a: assert property (en_edge |=> ADC_EXTERNAL_TRIGGER == ($past(ADC_ACTIVE) & PORT2_BIT7_LEVEL))
    else $error("trigger does not follow pin");
  rdata_idle_a: assert property (en_edge ##0 !RD |=> RDATA == 16'h0000) else $error("read data not cleared");
endmodule

bind pmx_port3_mux pmx_port3_mux_chk pmx_port3_mux_chk_i (.CLK(CLK), .NRST(NRST), .CE(CE), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PORT3_DATA(PORT3_DATA), .PORT3_DIR(PORT3_DIR),
  .ADC_ACTIVE(ADC_ACTIVE), .ADC_EXTERNAL_TRIGGER(ADC_EXTERNAL_TRIGGER), .PORT2_BIT7_LEVEL(PORT2_BIT7_LEVEL),
  .CLOCK_MONITOR(CLOCK_MONITOR),
  .COMPARE_EVENT(COMPARE_EVENT), .PULSE_GEN0_WAVE_A(PULSE_GEN0_WAVE_A), .PULSE_GEN0_WAVE_B(PULSE_GEN0_WAVE_B),
  .PORT3_OUT(PORT3_OUT), .PORT3_OE(PORT3_OE));

// *** tb/pmx_board.sv ***
// board circuitry on the shared pins
`timescale 1ns/100ps
module pmx_board (
  // chip side
  input wire logic [8:0] drv,
  input wire logic [8:0] oe,
  // board drive where the chip lets go
  input wire logic [8:0] ext,
  output logic [8:0] lvl
);
  // the board yields to the chip, so no pin ever sees contention
  assign lvl = oe & drv | ~oe & ext;
endmodule

// *** tb/pmx_port3_mux_tb_top.sv ***
// self-checking bench for the pin-function multiplexer
`timescale 1ns/100ps
module pmx_port3_mux_tb_top;
  import pmx_pkg::*;
  logic clk = 0, nrst = 0, ce = 1, wr = 0, rd = 0, adc = 0, cmon = 0, wa = 0, wb = 0, p2d = 0, p2r = 0;
  logic [3:0] addr = 0, cmp = 0;
  logic [15:0] wdata = 0, e_rd;
  logic [15:0] rdata;
  logic [7:0] p3d = 0, p3r = 0, p3lvl, e_ctl;
  logic [8:0] ext = 0, e_out, e_oe, own, per, dat, dir;
  logic [8:0] e_s1, e_s2, e_s3, e_lvl, e_plvl, e_own;
  logic e_adcs, e_trig;
  wire logic [8:0] pin, drv, oe;
  logic p2lvl, trig;
  int failures = 0, compares = 0, cyc = 0;
  bit [31:0] seed = 68703;
  pmx_port3_mux pmx_port3_mux_i (.CLK(clk), .NRST(nrst), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .PORT2_BIT7_DATA(p2d), .PORT2_BIT7_DIR(p2r), .PORT3_DATA(p3d), .PORT3_DIR(p3r),
    .PORT2_BIT7_LEVEL(p2lvl), .PORT3_LEVEL(p3lvl), .ADC_ACTIVE(adc), .ADC_EXTERNAL_TRIGGER(trig),
    .CLOCK_MONITOR(cmon), .COMPARE_EVENT(cmp), .PULSE_GEN0_WAVE_A(wa), .PULSE_GEN0_WAVE_B(wb),
    .PORT2_BIT7_IN(pin[0]), .PORT2_BIT7_OUT(drv[0]), .PORT2_BIT7_OE(oe[0]),
    .PORT3_IN(pin[8:1]), .PORT3_OUT(drv[8:1]), .PORT3_OE(oe[8:1]));
  pmx_board pmx_board_i (.drv(drv), .oe(oe), .ext(ext), .lvl(pin));
  //////////////////////////////////////////////////////////////////////////////
  function automatic bit [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr_reg(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rd_reg(logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
    forever #2 clk = ~clk;
  // reference model: one cycle from inputs to pin drive, clock enable freezes all
  assign own = {e_ctl[6:0], 2'b00};
  assign per = {wb, wa, cmp, cmon, 2'b00};
  assign dat = {p3d, p2d};
  assign dir = {p3r, p2r};
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (!nrst)
    begin
      e_out <= 9'h000;
      e_oe <= 9'h000;
      e_rd <= 16'h0000;
      e_ctl <= 8'h00;
      e_s1 <= 9'h000;
      e_s2 <= 9'h000;
      e_s3 <= 9'h000;
      e_lvl <= 9'h000;
      e_plvl <= 9'h000;
      e_own <= 9'h000;
      e_adcs <= 1'b0;
      e_trig <= 1'b0;
    end
    else if (ce)
    begin
      e_out <= own & per | ~own & dat;
      e_oe <= own | dir;
      if (!rd)
        e_rd <= 16'h0000;
      else if (addr == CTRL_OFS)
        e_rd <= {8'h00, e_ctl};
      else if (addr == PIN_LEVEL_OFS)
        e_rd <= {5'h00, e_trig, e_adcs, e_lvl};
      else if (addr == OWNER_OFS)
        e_rd <= {7'h00, e_own};
      else if (addr == DRIVE_OFS)
        e_rd <= {7'h00, e_oe};
      else
        e_rd <= 16'h0000;
      if (wr && addr == CTRL_OFS)
        e_ctl <= wdata[7:0];
      // three-stage filter: a level is taken only once the last two stages agree
      e_s1 <= pin;
      e_s2 <= e_s1;
      e_s3 <= e_s2;
      e_lvl <= ~(e_s2 ^ e_s3) & e_s3 | (e_s2 ^ e_s3) & e_lvl;
      e_plvl <= e_lvl;
      e_own <= own;
      e_adcs <= adc;
      e_trig <= adc & e_lvl[0];
    end
  end
  always @(negedge clk)
    if (cyc > 1)
    begin
      check("pin drive", 16'(drv), 16'(e_out));
      check("pin enable", 16'(oe), 16'(e_oe));
      check("read data", rdata, e_rd);
      check("pin level now", 16'({p3lvl, p2lvl}), 16'(e_plvl));
      check("trigger now", 16'(trig), 16'(e_trig));
    end
  // peripheral levels and clock enable change every cycle
  always @(posedge clk)
  begin
    {cmon, cmp, wa, wb} <= 7'(rnd());
    ce <= !nrst || rnd() % 16 != 0;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic blk();
    logic [31:0] r;
    r = rnd();
    @(posedge clk);
    ext <= r[8:0];
    p3d <= r[16:9];
    p3r <= r[24:17];
    p2d <= r[25];
    adc <= r[26];
    // trigger pin kept an input while sampled
    p2r <= r[27] & ~r[26];
    wr_reg(r[31:28], 16'(rnd()));
    wr_reg(CTRL_OFS, 16'(rnd()));
    rd_reg(r[29:28] == 2'b00 ? CTRL_OFS : r[31:28]);
    repeat (12) @(posedge clk);
    @(negedge clk);
    check("pin level", 16'({p3lvl, p2lvl} & ~own), 16'((dir & dat | ~dir & ext) & ~own));
    check("trigger", 16'(trig), 16'(adc & (p2r ? p2d : ext[0])));
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    nrst <= 1;
    repeat (150) blk();
    tally_and_finish();
  end
  initial
  begin
    #40000;
    failures++;
    tally_and_finish();
  end
endmodule
